/* verilog/pmp_partition_map.sv */
// Purpose: program memory map, partition decode, protection, id words
// Assumes: core and NVM controller signals synchronous to clk
// Notes:   one design file; registers over a plain strobe port
`timescale 1ns/100ps
`include "pmp_defines.svh"

module pmp_partition_map
    import pmp_pkg::*;
#(
    parameter logic [11:0] PART_CODE      = 12'hABC, // Arbitrary value
    parameter logic [5:0]  MAJOR_REVISION = 6'h01,   // Arbitrary value
    parameter logic [5:0]  MINOR_REVISION = 6'h02    // Arbitrary value
) (
    input  wire logic        clk,            // 200 MHz core clock
    input  wire logic        sys_rst,        // Async reset, active high
    // Core fetch path
    input  wire logic        irq_take,       // Pulse: vector to interrupt
    input  wire logic        pc_load,        // Pulse: load pc from pc_load_addr
    input  wire logic [14:0] pc_load_addr,   // Branch target
    input  wire logic        fetch_adv,      // Pulse: step pc
    output logic      [14:0] fetch_pc,       // Program counter
    output logic      [13:0] fetch_addr,     // Wrapped fetch word address
    input  wire logic [13:0] fetch_word,     // Word from flash for fetch_addr
    output logic      [13:0] fetch_instr,    // Registered fetched word
    output logic             mem_viol_rst,   // Pulse: execution violation reset
    // Core indirect data path
    input  wire logic [7:0]  indirect_pointer_high, // Pointer high byte
    input  wire logic [7:0]  indirect_pointer_low,  // Pointer low byte
    input  wire logic        ind_rd,         // Pulse: read indirect_data_port
    input  wire logic        ind_wr,         // Pulse: write indirect_data_port
    output logic      [13:0] pm_data_addr,   // Wrapped data-side flash address
    input  wire logic [13:0] pm_data_word,   // Word from flash for pm_data_addr
    output logic      [7:0]  ind_rdata,      // Low byte of program word
    output logic             ind_rvalid,     // Pulse: ind_rdata valid
    output logic             ind_stall,      // Extra cycle for program reads
    output logic             ind_ram_sel,    // Access goes to data memory
    // NVM controller
    input  wire logic        nvm_wr_req,     // Pulse: program write request
    input  wire logic [15:0] nvm_wr_addr,    // Target word address
    output logic             nvm_wr_ok,      // Pulse: write may proceed
    output logic             nvm_ee_sel,     // Write target is data EEPROM
    // Register port
    input  wire logic [3:0]  reg_addr,       // Register index
    input  wire logic [15:0] reg_wdata,      // Write data
    input  wire logic        reg_wr,         // Write strobe
    input  wire logic        reg_rd,         // Read strobe
    output logic      [15:0] reg_rdata       // Read data, cycle after strobe
);

    ////////////////////////////////////////////////////////////////////
    logic [10:0] cfg_reg;
    logic        write_error_flag;
    logic        memory_violation_flag;
    logic [13:0] last_boot;
    logic        boot_block_enable_n;
    logic        storage_area_enable_n;
    logic [2:0]  boot_size_select;
    logic [13:0] word_id;
    logic [13:0] word_rev;
    pmp_block_e  fetch_blk;
    pmp_block_e  wr_blk;
    logic        fetch_exec_ok;
    logic        wr_protected;
    logic        ind_pm;
    pmp_ird_e    ird_state;
    logic [14:0] pc_next;

    assign boot_block_enable_n   = cfg_reg[`PMP_CF_BOOT_BLOCK_ENABLE_N];
    assign storage_area_enable_n = cfg_reg[`PMP_CF_STORAGE_AREA_ENABLE_N];
    assign boot_size_select      = cfg_reg[`PMP_CF_BOOT_SIZE_SELECT];

    assign word_id  = {`PMP_ID_FIXED, PART_CODE};
    assign word_rev = {`PMP_REV_FIXED, MAJOR_REVISION, MINOR_REVISION};

    // Boot size: 111 gives 512 words, each step down doubles, clamp at half
    always_comb begin
        case (boot_size_select)
            3'h7:    last_boot = `PMP_BOOT_MIN_LAST;
            3'h6:    last_boot = 14'h03FF;
            3'h5:    last_boot = 14'h07FF;
            3'h4:    last_boot = 14'h0FFF;
            default: last_boot = `PMP_BOOT_MAX_LAST;
        endcase
    end

    function automatic pmp_block_e classify(input logic [13:0] a, input logic boot_block_enable_n_n,
                                            input logic storage_area_enable_n_n, input logic [13:0] lb);
        pmp_block_e b;
        b = PMP_BLK_APP;
        if (!storage_area_enable_n_n && a >= (`PMP_LAST_ADDR - `PMP_SAF_OFS))
            b = PMP_BLK_SAF;
        else if (!boot_block_enable_n_n && a <= lb)
            b = PMP_BLK_BOOT;
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Program counter and fetch path
    always_comb begin
        pc_next = fetch_pc;
        if (irq_take)
            pc_next = `PMP_INT_VEC;
        else if (pc_load)
            pc_next = pc_load_addr;
        else if (fetch_adv)
            pc_next = fetch_pc + 15'h0001;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            fetch_pc <= `PMP_RESET_VEC;
        else if (mem_viol_rst)
            fetch_pc <= `PMP_RESET_VEC;
        else
            fetch_pc <= pc_next;
    end

    assign fetch_addr = fetch_pc[13:0];
    assign fetch_blk  = classify(fetch_addr, boot_block_enable_n, storage_area_enable_n, last_boot);
    assign fetch_exec_ok = (fetch_blk != PMP_BLK_SAF);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fetch_instr  <= 14'h0000;
            mem_viol_rst <= 1'b0;
        end else begin
            fetch_instr  <= fetch_word;
            mem_viol_rst <= fetch_adv && !fetch_exec_ok && !mem_viol_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Indirect data path
    assign ind_pm       = indirect_pointer_high[`PMP_IND_PM_BIT];
    assign ind_ram_sel  = !ind_pm && (ind_rd || ind_wr);
    assign pm_data_addr = {indirect_pointer_high[5:0], indirect_pointer_low};
    assign ind_stall    = (ird_state == PMP_IRD_WAIT);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ird_state  <= PMP_IRD_IDLE;
            ind_rdata  <= 8'h00;
            ind_rvalid <= 1'b0;
        end else begin
            ind_rvalid <= 1'b0;
            case (ird_state)
                PMP_IRD_IDLE: begin
                    if (ind_rd && ind_pm)
                        ird_state <= PMP_IRD_WAIT;
                end
                PMP_IRD_WAIT: begin
                    ind_rdata  <= pm_data_word[7:0];
                    ind_rvalid <= 1'b1;
                    ird_state  <= PMP_IRD_DONE;
                end
                PMP_IRD_DONE: ird_state <= PMP_IRD_IDLE;
                default:      ird_state <= PMP_IRD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write protection
    assign nvm_ee_sel = nvm_wr_addr >= `PMP_EE_LO && nvm_wr_addr <= `PMP_EE_HI;
    assign wr_blk = classify(nvm_wr_addr[13:0], boot_block_enable_n, storage_area_enable_n, last_boot);

    always_comb begin
        if (nvm_ee_sel)
            wr_protected = !cfg_reg[`PMP_CF_EEPROM_WRITE_PROTECT_N];
        else if (nvm_wr_addr >= `PMP_CFG_LO && nvm_wr_addr <= `PMP_CFG_HI)
            wr_protected = !cfg_reg[`PMP_CF_CONFIG_WRITE_PROTECT_N];
        else if (nvm_wr_addr == `PMP_ID_ADDR || nvm_wr_addr == `PMP_REV_ADDR)
            wr_protected = 1'b1;
        else if (nvm_wr_addr[15])
            wr_protected = 1'b1;
        else begin
            case (wr_blk)
                PMP_BLK_BOOT: wr_protected = !cfg_reg[`PMP_CF_BOOT_WRITE_PROTECT_N];
                PMP_BLK_SAF:  wr_protected = !cfg_reg[`PMP_CF_STORAGE_WRITE_PROTECT_N];
                PMP_BLK_APP:  wr_protected = !cfg_reg[`PMP_CF_APP_WRITE_PROTECT_N];
                default:      wr_protected = 1'b1;
            endcase
        end
    end

    assign nvm_wr_ok = nvm_wr_req && !wr_protected;

    ////////////////////////////////////////////////////////////////////
    // Status flags: hardware update wins over software write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            write_error_flag <= 1'b0;
        else if (nvm_wr_req && wr_protected)
            write_error_flag <= 1'b1;
        else if (reg_wr && reg_addr == `PMP_R_CLEAR && reg_wdata[0])
            write_error_flag <= 1'b0;
    end

    // Active-low flag: violation clears it, software sets it back
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            memory_violation_flag <= 1'b1;
        else if (fetch_adv && !fetch_exec_ok)
            memory_violation_flag <= 1'b0;
        else if (reg_wr && reg_addr == `PMP_R_CLEAR && reg_wdata[1])
            memory_violation_flag <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration: protect bits only go active except on bulk erase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            cfg_reg <= `PMP_CFG_RESET;
        else if (reg_wr && reg_addr == `PMP_R_BULK && reg_wdata[0])
            cfg_reg <= `PMP_CFG_RESET;
        else if (reg_wr && reg_addr == `PMP_R_CFG) begin
            cfg_reg[10:5] <= cfg_reg[10:5] & reg_wdata[10:5];
            cfg_reg[`PMP_CF_BOOT_BLOCK_ENABLE_N]  <= cfg_reg[`PMP_CF_BOOT_BLOCK_ENABLE_N] & reg_wdata[`PMP_CF_BOOT_BLOCK_ENABLE_N];
            cfg_reg[`PMP_CF_STORAGE_AREA_ENABLE_N] <= cfg_reg[`PMP_CF_STORAGE_AREA_ENABLE_N] & reg_wdata[`PMP_CF_STORAGE_AREA_ENABLE_N];
            if (cfg_reg[`PMP_CF_BOOT_BLOCK_ENABLE_N])
                cfg_reg[`PMP_CF_BOOT_SIZE_SELECT] <= reg_wdata[`PMP_CF_BOOT_SIZE_SELECT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read port; id and revision ignore writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            reg_rdata <= 16'h0000;
        else if (reg_rd) begin
            case (reg_addr)
                `PMP_R_ID:       reg_rdata <= {2'h0, word_id};
                `PMP_R_REV:      reg_rdata <= {2'h0, word_rev};
                `PMP_R_CFG:      reg_rdata <= {5'h00, cfg_reg};
                `PMP_R_STATUS:   reg_rdata <= {14'h0000, memory_violation_flag, write_error_flag};
                `PMP_R_LASTBOOT: reg_rdata <= {2'h0, last_boot};
                default:         reg_rdata <= 16'h0000;
            endcase
        end else
            reg_rdata <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////
    a_irq_vector: assert property (@(posedge clk) disable iff (sys_rst)
        irq_take && !mem_viol_rst |=> fetch_pc == 15'h0004)
        else $error("interrupt did not vector to 0004h");

    a_ird_latency: assert property (@(posedge clk) disable iff (sys_rst)
        ird_state == PMP_IRD_IDLE && ind_rd && ind_pm |-> ##2 ind_rvalid)
        else $error("indirect program read latency wrong");

    a_ird_data: assert property (@(posedge clk) disable iff (sys_rst)
        ind_stall |=> ind_rdata == $past(pm_data_word[7:0]))
        else $error("indirect read returned wrong byte");

    a_wr_error: assert property (@(posedge clk) disable iff (sys_rst)
        nvm_wr_req && wr_protected |-> !nvm_wr_ok ##1 write_error_flag)
        else $error("protected write not refused");

    a_viol_reset: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_adv && fetch_blk == PMP_BLK_SAF && !mem_viol_rst |=> mem_viol_rst && !memory_violation_flag)
        else $error("storage fetch did not raise violation");

    a_prot_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        !cfg_reg[`PMP_CF_APP_WRITE_PROTECT_N] && !(reg_wr && reg_addr == `PMP_R_BULK) |=> !cfg_reg[`PMP_CF_APP_WRITE_PROTECT_N])
        else $error("protection released without bulk erase");

    a_saf_decode: assert property (@(posedge clk) disable iff (sys_rst)
        !storage_area_enable_n && fetch_addr >= 14'h3F80 |-> fetch_blk == PMP_BLK_SAF)
        else $error("storage area decode wrong");

    a_id_read: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == `PMP_R_ID |=> reg_rdata[13:12] == 2'h3)
        else $error("id word fixed bits wrong");

    a_default_app: assert property (@(posedge clk) disable iff (sys_rst)
        boot_block_enable_n && storage_area_enable_n |-> fetch_blk == PMP_BLK_APP)
        else $error("default map not all application");

    // Fetch and map checks
    a_pc_step: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_adv && !irq_take && !pc_load && !mem_viol_rst
        |=> fetch_pc == $past(fetch_pc) + 15'h0001)
        else $error("program counter did not step");

    a_viol_restart: assert property (@(posedge clk) disable iff (sys_rst)
        mem_viol_rst
        |=> fetch_pc == 15'h0000)
        else $error("violation did not restart at 0000h");

    a_boot_decode: assert property (@(posedge clk) disable iff (sys_rst)
        !boot_block_enable_n && storage_area_enable_n && nvm_wr_addr[13:0] <= last_boot
        |-> wr_blk == PMP_BLK_BOOT)
        else $error("boot block decode wrong");

    a_app_decode: assert property (@(posedge clk) disable iff (sys_rst)
        boot_block_enable_n && !storage_area_enable_n && nvm_wr_addr[13:0] < 14'h3F80
        |-> wr_blk == PMP_BLK_APP)
        else $error("application block decode wrong");

    a_boot_clamp: assert property (@(posedge clk) disable iff (sys_rst)
        boot_size_select <= 3'h3
        |-> last_boot == 14'h1FFF)
        else $error("boot size not clamped to half");

    a_size_lock: assert property (@(posedge clk) disable iff (sys_rst)
        !boot_block_enable_n && !(reg_wr && reg_addr == `PMP_R_BULK)
        |=> $stable(boot_size_select))
        else $error("boot size changed while locked");

    // Indirect path checks
    a_ram_route: assert property (@(posedge clk) disable iff (sys_rst)
        ird_state == PMP_IRD_IDLE && (ind_rd || ind_wr) && !ind_pm
        |=> !ind_stall)
        else $error("data memory access stalled");

    a_pm_write: assert property (@(posedge clk) disable iff (sys_rst)
        ind_wr && !ind_rd && ind_pm && !ind_stall
        |-> !ind_ram_sel ##1 !ind_stall)
        else $error("program memory write acted on");

    a_ird_single: assert property (@(posedge clk) disable iff (sys_rst)
        ind_rvalid
        |-> !ind_stall ##1 !ind_rvalid && !ind_stall)
        else $error("indirect read result repeated");

    // Protection, flag and register checks
    a_id_refuse: assert property (@(posedge clk) disable iff (sys_rst)
        nvm_wr_req && (nvm_wr_addr == `PMP_ID_ADDR || nvm_wr_addr == `PMP_REV_ADDR)
        |-> !nvm_wr_ok)
        else $error("write to id words allowed");

    a_ee_decode: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1
        |-> nvm_ee_sel == (nvm_wr_addr[15:8] == 8'hF0))
        else $error("eeprom window decode wrong");

    a_err_hold: assert property (@(posedge clk) disable iff (sys_rst)
        write_error_flag && !(reg_wr && reg_addr == `PMP_R_CLEAR && reg_wdata[0])
        |=> write_error_flag)
        else $error("write error dropped without clear");

    a_viol_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !memory_violation_flag && !(reg_wr && reg_addr == `PMP_R_CLEAR && reg_wdata[1])
        |=> !memory_violation_flag)
        else $error("violation flag restored on its own");

    a_rev_read: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == `PMP_R_REV
        |=> reg_rdata[13:12] == 2'h2)
        else $error("revision word fixed bits wrong");

endmodule

/* verilog/pmp_defines.svh */
// Purpose: constants for the program memory partition map
// Assumes: word addresses, 14-bit program words
// Notes:   offsets are program-space word addresses
`ifndef PMP_DEFINES_SVH
`define PMP_DEFINES_SVH
`define PMP_PC_W          15
`define PMP_WORD_W        14
`define PMP_IMPL_W        14
`define PMP_LAST_ADDR     14'h3FFF
`define PMP_RESET_VEC     15'h0000
`define PMP_INT_VEC       15'h0004
`define PMP_SAF_OFS       14'h007F
`define PMP_APP_END_OFS   14'h0080
`define PMP_BOOT_MIN_LAST 14'h01FF
`define PMP_BOOT_MAX_LAST 14'h1FFF
`define PMP_REV_ADDR      16'h8005
`define PMP_ID_ADDR       16'h8006
`define PMP_CFG_LO        16'h8007
`define PMP_CFG_HI        16'h800B
`define PMP_EE_LO         16'hF000
`define PMP_EE_HI         16'hF0FF
`define PMP_ID_FIXED      2'h3
`define PMP_REV_FIXED     2'h2
`define PMP_IND_PM_BIT    7
`define PMP_CFG_RESET     11'h7FF
// Register port map for the loose bits
`define PMP_R_ID          4'h0
`define PMP_R_REV         4'h1
`define PMP_R_CFG         4'h2
`define PMP_R_STATUS      4'h3
`define PMP_R_CLEAR       4'h4
`define PMP_R_BULK        4'h5
`define PMP_R_LASTBOOT    4'h6
// Config register fields
`define PMP_CF_BOOT_SIZE_SELECT     2:0
`define PMP_CF_BOOT_BLOCK_ENABLE_N       3
`define PMP_CF_STORAGE_AREA_ENABLE_N      4
`define PMP_CF_APP_WRITE_PROTECT_N     5
`define PMP_CF_BOOT_WRITE_PROTECT_N       6
`define PMP_CF_CONFIG_WRITE_PROTECT_N       7
`define PMP_CF_EEPROM_WRITE_PROTECT_N       8
`define PMP_CF_STORAGE_WRITE_PROTECT_N     9
`endif

/* verilog/pmp_pkg.sv */
// Purpose: types for the program memory partition map
// Assumes: nothing
// Notes:   constants live in pmp_defines.svh
package pmp_pkg;
    typedef enum logic [1:0] {
        PMP_BLK_BOOT,
        PMP_BLK_APP,
        PMP_BLK_SAF,
        PMP_BLK_OTHER
    } pmp_block_e;
    typedef enum logic [1:0] {
        PMP_IRD_IDLE,
        PMP_IRD_WAIT,
        PMP_IRD_DONE
    } pmp_ird_e;
endpackage

/* verification/pmp_flash_model.sv */
// Purpose: behavioural flash array behind the fetch and data-side read ports
// Assumes: combinational read, one fixed pattern per word address
// Notes:   the testbench derives its expected words from the same pattern
`timescale 1ns/100ps

module pmp_flash_model (
    input  wire logic [13:0] fetch_addr,   // Fetch word address, wrapped
    input  wire logic [13:0] pm_data_addr, // Data-side word address, wrapped
    output logic      [13:0] fetch_word,   // Word at fetch_addr
    output logic      [13:0] pm_data_word  // Word at pm_data_addr
);
    ////////////////////////////////////////////////////////////////////////////
    // Two independent ports over 16K words, so fetch never waits on data
    assign fetch_word   = {fetch_addr[6:0], ~fetch_addr[13:7]};
    assign pm_data_word = {pm_data_addr[6:0], ~pm_data_addr[13:7]};
endmodule

/* verification/tb_pmp_partition_map.sv */
// Purpose: self-checking bench for the program memory partition map
// Assumes: bench drives inputs by non-blocking assignment at rising edges
// Notes:   flash contents come from pmp_flash_model
`timescale 1ns/100ps
`include "pmp_defines.svh"

module tb_pmp_partition_map;
    localparam logic [11:0] PCODE = 12'h5A3; // Arbitrary value
    localparam logic [5:0]  MAJ   = 6'h15;   // Arbitrary value
    localparam logic [5:0]  MIN   = 6'h2C;   // Arbitrary value
    localparam logic [15:0] BOOT_LAST [8] = '{16'h1FFF, 16'h1FFF, 16'h1FFF, 16'h1FFF,
                                              16'h0FFF, 16'h07FF, 16'h03FF, 16'h01FF};
    logic        clk, sys_rst, irq_take, pc_load, fetch_adv, ind_rd, ind_wr, nvm_wr_req, reg_wr, reg_rd;
    logic        mem_viol_rst, ind_rvalid, ind_stall, ind_ram_sel, nvm_wr_ok, nvm_ee_sel;
    logic [14:0] pc_load_addr, fetch_pc;
    logic [13:0] fetch_addr, fetch_word, fetch_instr, pm_data_addr, pm_data_word;
    logic [7:0]  ptr_high, ptr_low, ind_rdata;
    logic [15:0] nvm_wr_addr, reg_wdata, reg_rdata;
    logic [3:0]  reg_addr;
    int          bad_count, checks_done, cycles;

    pmp_partition_map #(.PART_CODE(PCODE), .MAJOR_REVISION(MAJ), .MINOR_REVISION(MIN)) i_pmp_partition_map (
        .clk(clk), .sys_rst(sys_rst), .irq_take(irq_take), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
        .fetch_adv(fetch_adv), .fetch_pc(fetch_pc), .fetch_addr(fetch_addr), .fetch_word(fetch_word),
        .fetch_instr(fetch_instr), .mem_viol_rst(mem_viol_rst), .indirect_pointer_high(ptr_high),
        .indirect_pointer_low(ptr_low), .ind_rd(ind_rd), .ind_wr(ind_wr), .pm_data_addr(pm_data_addr),
        .pm_data_word(pm_data_word), .ind_rdata(ind_rdata), .ind_rvalid(ind_rvalid), .ind_stall(ind_stall),
        .ind_ram_sel(ind_ram_sel), .nvm_wr_req(nvm_wr_req), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_ok(nvm_wr_ok),
        .nvm_ee_sel(nvm_ee_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    pmp_flash_model i_pmp_flash_model (
        .fetch_addr(fetch_addr), .pm_data_addr(pm_data_addr),
        .fetch_word(fetch_word), .pm_data_word(pm_data_word));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [13:0] flash_word(input logic [13:0] a);
        return {a[6:0], ~a[13:7]};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_word({15'h0, got}, {15'h0, exp}, msg);
    endtask

    task automatic test_done(input string name);
        $display("test %s done, checks %0d mismatches %0d", name, checks_done, bad_count);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Access tasks
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_check(input logic [3:0] a, input logic [15:0] exp, input string msg);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk_word(reg_rdata, exp, msg);
    endtask

    task automatic pc_step(input logic ld, input logic adv, input logic irq, input logic [14:0] a);
        @(posedge clk);
        pc_load      <= ld;
        fetch_adv    <= adv;
        irq_take     <= irq;
        pc_load_addr <= a;
        @(posedge clk);
        pc_load      <= 1'b0;
        fetch_adv    <= 1'b0;
        irq_take     <= 1'b0;
        #1;
    endtask

    task automatic ind_read(input logic [7:0] h, input logic [7:0] l);
        logic [13:0] w;
        w = flash_word({h[5:0], l});
        @(posedge clk);
        ptr_high <= h;
        ptr_low  <= l;
        ind_rd   <= 1'b1;
        @(posedge clk);
        ind_rd   <= 1'b0;
        #1;
        chk_bit(ind_stall, 1'b1, "indirect wait state");
        chk_bit(ind_ram_sel, 1'b0, "program read routed to RAM");
        @(posedge clk);
        #1;
        chk_bit(ind_rvalid, 1'b1, "indirect read valid");
        chk_word({8'h00, ind_rdata}, {8'h00, w[7:0]}, "indirect read data");
    endtask

    task automatic nvm_try(input logic [15:0] a, input logic ok, input logic ee, input string msg);
        @(posedge clk);
        nvm_wr_req  <= 1'b1;
        nvm_wr_addr <= a;
        #1;
        chk_bit(nvm_wr_ok, ok, msg);
        chk_bit(nvm_ee_sel, ee, msg);
        @(posedge clk);
        nvm_wr_req  <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            $display("[FAIL] t=%0t run did not finish", $time);
            end_sim();
        end
    end

    initial begin
        sys_rst = 1'b1; irq_take = 1'b0; pc_load = 1'b0; fetch_adv = 1'b0; ind_rd = 1'b0; ind_wr = 1'b0;
        nvm_wr_req = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; pc_load_addr = 15'h0000; ptr_high = 8'h00;
        ptr_low = 8'h00; nvm_wr_addr = 16'h0000; reg_wdata = 16'h0000; reg_addr = 4'h0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk_word({1'b0, fetch_pc}, 16'h0000, "reset fetch address");
        reg_check(`PMP_R_ID, {4'h3, PCODE}, "id word");
        reg_check(`PMP_R_REV, {4'h2, MAJ, MIN}, "revision word");
        reg_write(`PMP_R_ID, 16'h0000);
        reg_write(`PMP_R_REV, 16'h0000);
        reg_check(`PMP_R_ID, {4'h3, PCODE}, "id after write");
        reg_check(`PMP_R_REV, {4'h2, MAJ, MIN}, "revision after write");
        reg_check(`PMP_R_CFG, 16'h07FF, "config default");
        reg_check(`PMP_R_STATUS, 16'h0002, "status default");
        reg_check(4'hF, 16'h0000, "unmapped read");
        test_done("registers");
        pc_step(1'b0, 1'b0, 1'b1, 15'h0000);
        chk_word({1'b0, fetch_pc}, 16'h0004, "interrupt vector");
        pc_step(1'b1, 1'b0, 1'b0, 15'h7FFF);
        chk_word({2'b0, fetch_addr}, 16'h3FFF, "top address wrap");
        pc_step(1'b0, 1'b1, 1'b0, 15'h0000);
        chk_word({1'b0, fetch_pc}, 16'h0000, "counter wrap");
        pc_step(1'b1, 1'b0, 1'b0, 15'h4123);
        chk_word({2'b0, fetch_addr}, 16'h0123, "fetch wrap");
        ind_read(8'hBF, 8'hFE);
        chk_word({2'b0, fetch_instr}, {2'b0, flash_word(14'h0123)}, "fetch beside read");
        ind_read(8'hC1, 8'h23);
        @(posedge clk);
        ptr_high <= 8'h12;
        ind_wr   <= 1'b1;
        #1;
        chk_bit(ind_ram_sel, 1'b1, "data memory access");
        @(posedge clk);
        ptr_high <= 8'h80;
        #1;
        chk_bit(ind_ram_sel, 1'b0, "program write to RAM");
        @(posedge clk);
        ind_wr   <= 1'b0;
        #1;
        chk_bit(ind_rvalid, 1'b0, "program write has no effect");
        chk_word({8'h00, ind_rdata}, {2'b0, flash_word(14'h0123)} & 16'h00FF, "read byte stands");
        test_done("fetch and indirect");
        reg_write(`PMP_R_CFG, 16'h07DF);
        nvm_try(16'h0100, 1'b0, 1'b0, "app protected");
        reg_check(`PMP_R_STATUS, 16'h0003, "write error set");
        reg_write(`PMP_R_CFG, 16'h07FF);
        reg_check(`PMP_R_CFG, 16'h07DF, "protection sticks");
        reg_write(`PMP_R_CLEAR, 16'h0001);
        reg_check(`PMP_R_STATUS, 16'h0002, "write error cleared");
        for (int c = 0; c < 8; c++) begin
            reg_write(`PMP_R_BULK, 16'h0001);
            reg_write(`PMP_R_CFG, 16'h07F8 | 16'(c));
            reg_write(`PMP_R_CFG, 16'h07F0 | 16'(c));
            reg_check(`PMP_R_LASTBOOT, BOOT_LAST[c], "boot end");
        end
        reg_write(`PMP_R_CFG, 16'h07B7);
        nvm_try(16'h01FF, 1'b0, 1'b0, "boot protected");
        nvm_try(16'h0200, 1'b1, 1'b0, "app above boot");
        reg_write(`PMP_R_CLEAR, 16'h0001);
        test_done("protection and boot");
        reg_write(`PMP_R_BULK, 16'h0001);
        reg_write(`PMP_R_CFG, 16'h05EF);
        nvm_try(16'h3F7F, 1'b1, 1'b0, "app below storage");
        nvm_try(16'h3F80, 1'b0, 1'b0, "storage protected");
        nvm_try(16'h3FFF, 1'b0, 1'b0, "storage last word");
        reg_write(`PMP_R_CLEAR, 16'h0001);
        pc_step(1'b1, 1'b0, 1'b0, 15'h3F7F);
        pc_step(1'b0, 1'b1, 1'b0, 15'h0000);
        chk_bit(mem_viol_rst, 1'b0, "app fetch allowed");
        pc_step(1'b0, 1'b1, 1'b0, 15'h0000);
        chk_bit(mem_viol_rst, 1'b1, "storage fetch violates");
        @(posedge clk);
        #1;
        chk_word({1'b0, fetch_pc}, 16'h0000, "violation restarts");
        reg_check(`PMP_R_STATUS, 16'h0000, "violation flag cleared");
        reg_write(`PMP_R_CLEAR, 16'h0002);
        reg_check(`PMP_R_STATUS, 16'h0002, "violation flag re-armed");
        test_done("storage area");
        reg_write(`PMP_R_BULK, 16'h0001);
        nvm_try(16'hF000, 1'b1, 1'b1, "eeprom first");
        nvm_try(16'hF0FF, 1'b1, 1'b1, "eeprom last");
        nvm_try(16'hF100, 1'b0, 1'b0, "above eeprom");
        nvm_try(16'hEFFF, 1'b0, 1'b0, "below eeprom");
        nvm_try(16'h8006, 1'b0, 1'b0, "id word write");
        nvm_try(16'h8005, 1'b0, 1'b0, "revision word write");
        nvm_try(16'h8007, 1'b1, 1'b0, "config open");
        reg_write(`PMP_R_CFG, 16'h067F);
        nvm_try(16'hF000, 1'b0, 1'b1, "eeprom protected");
        nvm_try(16'h800B, 1'b0, 1'b0, "config protected");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        reg_check(`PMP_R_CFG, 16'h07FF, "config after reset");
        test_done("eeprom and reset");
        end_sim();
    end
endmodule
